// File: hw/wit_pkg.sv
// Constants shared by the watchdog/interval timer and its settle counter.
// Assumes an 8-bit peripheral register port with 32-bit byte addresses.
package wit_pkg;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [31:0] OSC_SETTLE_ADDR = 32'hFFFFF380;
   localparam logic [31:0] OVF_SELECT_ADDR = 32'hFFFFF382;
   localparam logic [31:0] WDT_MODE_ADDR = 32'hFFFFF384;

   // ----------------------------------------
   // Fields and reset values
   // ----------------------------------------
   localparam int RESTART_BIT = 7;
   localparam int MODE_SEL_BIT = 4;
   localparam logic [7:0] OSC_SETTLE_RST = 8'h04;
   localparam logic [7:0] OVF_SELECT_RST = 8'h00;
   localparam logic [7:0] WDT_MODE_RST = 8'h00;
   localparam logic [2:0] SETTLE_CODE_MAX = 3'h4;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CNT_W = 22;
   localparam int PRESCALE_W = 10;
   localparam int SETTLE_W = 19;
   localparam logic [2:0] HIGHEST_RANK = 3'h0;

   // Overflow exponent of the main clock period per select code
   function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
      logic [4:0] e;
      e = 5'h0E + {2'h0, sel};
      if (sel == 3'h7) begin
         e = 5'h16;
      end
      return e;
   endfunction

   // Settle exponent per code; prohibited codes never get stored
   function automatic logic [4:0] settle_exp(input logic [2:0] code);
      logic [4:0] e;
      e = 5'h0F + {2'h0, code};
      if (code == 3'h0) begin
         e = 5'h0E;
      end
      return e;
   endfunction

endpackage

// File: hw/wit_settle.sv
// Oscillation settle wait counter run after a STOP release.
// Assumes osc_running comes straight from the oscillator, outside the clock domain.
`timescale 1ns/10ps
`default_nettype none

module wit_settle (
   input wire logic core_clk, // Main clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic stop_release, // One-cycle STOP release pulse
   input wire logic osc_running, // Oscillator started, asynchronous level
   input wire logic [2:0] settle_code, // Selected settle code
   input wire logic [4:0] exp_trim, // Exponent reduction for simulation
   output logic settle_busy, // Wait in progress
   output logic settle_done // One-cycle end of wait
);

   typedef enum logic [1:0] {
      WIT_ST_IDLE = 2'h0,
      WIT_ST_OSC = 2'h1,
      WIT_ST_COUNT = 2'h3
   } wit_settle_t;

   wit_settle_t state_r, state_nxt;
   logic osc_s1_r, osc_s2_r;
   logic [wit_pkg::SETTLE_W-1:0] cnt_r, cnt_nxt, last_cnt;
   logic busy_nxt, done_nxt;

   // ----------------------------------------
   // Oscillator synchroniser
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
      end else begin
         osc_s1_r <= osc_running;
         osc_s2_r <= osc_s1_r;
      end
   end

   // ----------------------------------------
   // Wait sequence
   // ----------------------------------------
   always_comb begin
      last_cnt = wit_pkg::SETTLE_W'((20'h1 << (wit_pkg::settle_exp(settle_code) - exp_trim))
         - 20'h1);
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      unique case (state_r)
         WIT_ST_IDLE: begin
            cnt_nxt = '0;
            if (stop_release) begin
               state_nxt = WIT_ST_OSC;
            end
         end
         WIT_ST_OSC: begin
            // Start-up time of the oscillator is not part of the wait
            if (osc_s2_r) begin // RULE16
               state_nxt = WIT_ST_COUNT;
            end
         end
         WIT_ST_COUNT: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == last_cnt) begin // RULE14
               state_nxt = WIT_ST_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = WIT_ST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != WIT_ST_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= WIT_ST_IDLE;
         cnt_r <= '0;
         settle_busy <= 1'b0;
         settle_done <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         settle_busy <= busy_nxt;
         settle_done <= done_nxt;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   osc_wait_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE16
      (state_r == WIT_ST_OSC && !osc_s2_r) |=> (state_r == WIT_ST_OSC && cnt_r == '0))
      else $error("settle counted before oscillator start");

   settle_cover_c: cover property (@(posedge core_clk) disable iff (sys_rst) settle_done);

endmodule

`default_nettype wire

// File: hw/wit_timer.sv
// Watchdog / interval timer with oscillation settle select register.
// Assumes idle, stop and subclock flags come from logic on core_clk.
//
// Summary of operation
// [RULE1] Mode-select 1 runs loop watchdog; overflow raises the non-maskable request.
// [RULE2] Mode-select 0 runs interval timer; every interval raises an interrupt.
// [RULE3] Writing 1 to restart bit 7 starts, and later clears and restarts, counting.
// [RULE4] Restart bit is sticky; writing 0 ignored; only reset stops counting.
// [RULE5] Mode-select bit is sticky once set; only reset returns to interval mode.
// [RULE6] Watchdog timeout raises only the non-maskable request, never a reset.
// [RULE7] Low ten prescaler bits are not cleared, so first period may be shorter.
// [RULE8] Counter halts in IDLE and STOP, keeps counting in HALT.
// [RULE9] Software restarts the counter before entering IDLE or STOP.
// [RULE10] Counter suspends and holds its value while the CPU runs on subclock.
// [RULE11] Interval overflow raises maskable request under mask flag and priority field.
// [RULE12] Interval request defaults to the highest maskable priority.
// [RULE13] Overflow periods are 2^14 to 2^20 and 2^22 main clocks.
// [RULE14] Settle codes 0 to 4 select 2^14, 2^16 to 2^19 clocks.
// [RULE15] Settle register resets to 04H.
// [RULE16] Settle wait counts only after oscillation has started.
// [RULE17] Restart bit 0 leaves counting off; writing 1 clears and starts.
// [RULE18] Overflow select holds codes 0 to 7 ascending, reset 00H.
// [RULE19] Mode register resets 00H; restart bit 7, mode bit 4, others read 0.
// [RULE20] Each overflow pulses the request one cycle; counting wraps on.
// [RULE21] New overflow select takes effect at the next restart.
`timescale 1ns/10ps
`default_nettype none

module wit_timer #(
   parameter logic [4:0] EXP_TRIM = 5'h00 // Shortens all periods by 2^EXP_TRIM
) (
   input wire logic core_clk, // Main clock, 50 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [31:0] reg_addr, // Register byte address
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, one cycle after reg_rd
   input wire logic idle_mode, // CPU in IDLE
   input wire logic stop_mode, // CPU in software STOP
   input wire logic subclk_sel, // CPU runs from subclock
   input wire logic stop_release, // STOP release pulse
   input wire logic osc_running, // Oscillator started, asynchronous
   input wire logic interval_irq_mask, // Mask flag of interval request
   input wire logic [2:0] interval_irq_priority, // Priority field of interval request
   output logic loop_nmi_request, // Non-maskable watchdog request pulse
   output logic interval_irq_request, // Maskable interval request pulse
   output logic [2:0] interval_irq_level, // Priority given with the request
   output logic [2:0] interval_irq_rank, // Default rank among maskable sources
   output logic settle_busy, // Settle wait in progress
   output logic settle_done // Settle wait ended
);

   logic run_r, run_nxt, mode_r, mode_nxt;
   logic [2:0] ovf_sel_r, ovf_sel_nxt, sel_act_r, sel_act_nxt, settle_r, settle_nxt;
   logic [wit_pkg::CNT_W-1:0] cnt_r, cnt_nxt, ovf_mask;
   logic cnt_en, ovf, restart;
   logic nmi_nxt, irq_nxt;
   logic [7:0] rdata_nxt;
   logic [2:0] level_nxt;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_comb begin
      restart = reg_wr && reg_addr == wit_pkg::WDT_MODE_ADDR
         && reg_wdata[wit_pkg::RESTART_BIT];
      run_nxt = run_r | restart; // RULE4
      mode_nxt = mode_r; // RULE5
      if (reg_wr && reg_addr == wit_pkg::WDT_MODE_ADDR && reg_wdata[wit_pkg::MODE_SEL_BIT]) begin
         mode_nxt = 1'b1;
      end
      ovf_sel_nxt = ovf_sel_r;
      if (reg_wr && reg_addr == wit_pkg::OVF_SELECT_ADDR) begin
         ovf_sel_nxt = reg_wdata[2:0]; // RULE18
      end
      // Latched copy avoids a period cut short by a mid-count reselect
      sel_act_nxt = restart ? ovf_sel_nxt : sel_act_r; // RULE21
      settle_nxt = settle_r;
      // Prohibited codes are dropped so the settle wait stays defined
      if (reg_wr && reg_addr == wit_pkg::OSC_SETTLE_ADDR
         && reg_wdata[2:0] <= wit_pkg::SETTLE_CODE_MAX) begin
         settle_nxt = reg_wdata[2:0]; // RULE14
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         run_r <= wit_pkg::WDT_MODE_RST[wit_pkg::RESTART_BIT]; // RULE17
         mode_r <= wit_pkg::WDT_MODE_RST[wit_pkg::MODE_SEL_BIT]; // RULE19
         ovf_sel_r <= wit_pkg::OVF_SELECT_RST[2:0];
         sel_act_r <= wit_pkg::OVF_SELECT_RST[2:0];
         settle_r <= wit_pkg::OSC_SETTLE_RST[2:0]; // RULE15
      end else begin
         run_r <= run_nxt;
         mode_r <= mode_nxt;
         ovf_sel_r <= ovf_sel_nxt;
         sel_act_r <= sel_act_nxt;
         settle_r <= settle_nxt;
      end
   end

   // ----------------------------------------
   // Counter and overflow
   // ----------------------------------------
   always_comb begin
      cnt_en = run_r && !idle_mode && !stop_mode && !subclk_sel; // RULE8 RULE10
      ovf_mask = wit_pkg::CNT_W'((23'h1 << (wit_pkg::ovf_exp(sel_act_r) - EXP_TRIM)) - 23'h1);
      ovf = cnt_en && ((cnt_r & ovf_mask) == ovf_mask); // RULE13
      cnt_nxt = cnt_en ? cnt_r + 1'b1 : cnt_r; // RULE20
      if (restart) begin
         // Prescaler stages stay running, so the first period can be short
         cnt_nxt = {{(wit_pkg::CNT_W - wit_pkg::PRESCALE_W){1'b0}},
            cnt_nxt[wit_pkg::PRESCALE_W-1:0]}; // RULE3 RULE7
      end
      nmi_nxt = ovf && mode_r && !restart; // RULE1 RULE6
      irq_nxt = ovf && !mode_r && !restart && !interval_irq_mask; // RULE2 RULE11
      level_nxt = interval_irq_priority; // RULE11
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
         loop_nmi_request <= 1'b0;
         interval_irq_request <= 1'b0;
         interval_irq_level <= 3'h0;
         interval_irq_rank <= wit_pkg::HIGHEST_RANK; // RULE12
      end else begin
         cnt_r <= cnt_nxt;
         loop_nmi_request <= nmi_nxt;
         interval_irq_request <= irq_nxt;
         interval_irq_level <= level_nxt;
         interval_irq_rank <= wit_pkg::HIGHEST_RANK;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            wit_pkg::OSC_SETTLE_ADDR: rdata_nxt = {5'h00, settle_r};
            wit_pkg::OVF_SELECT_ADDR: rdata_nxt = {5'h00, ovf_sel_r};
            wit_pkg::WDT_MODE_ADDR: rdata_nxt = {run_r, 2'h0, mode_r, 4'h0}; // RULE19
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Settle counter
   // ----------------------------------------
   wit_settle u_settle (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .stop_release(stop_release),
      .osc_running(osc_running),
      .settle_code(settle_r),
      .exp_trim(EXP_TRIM),
      .settle_busy(settle_busy),
      .settle_done(settle_done)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   nmi_wdt_only_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
      loop_nmi_request |-> $past(mode_r) && !interval_irq_request)
      else $error("nmi outside watchdog mode");

   irq_interval_only_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
      interval_irq_request |-> !$past(mode_r) && !$past(interval_irq_mask))
      else $error("interval request in wrong mode or masked");

   run_sticky_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
      run_r |=> run_r)
      else $error("restart bit cleared by software");

   mode_sticky_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
      mode_r |=> mode_r)
      else $error("mode bit cleared by software");

   restart_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
      restart |=> cnt_r[wit_pkg::CNT_W-1:wit_pkg::PRESCALE_W] == '0 && run_r)
      else $error("restart did not clear the count");

   standby_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE8
      (idle_mode || stop_mode || subclk_sel) && !restart |=> $stable(cnt_r))
      else $error("counter moved while halted");

   req_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE20
      (loop_nmi_request || interval_irq_request) |=> !loop_nmi_request && !interval_irq_request)
      else $error("request longer than one cycle");

   settle_reset_a: assert property (@(posedge core_clk) // RULE15
      sys_rst |=> settle_r == wit_pkg::OSC_SETTLE_RST[2:0] && !run_r && !mode_r)
      else $error("wrong reset value");

   ovf_point_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
      (loop_nmi_request || interval_irq_request) |-> (cnt_r & ovf_mask) == '0)
      else $error("overflow at wrong count");

   nmi_cover_c: cover property (@(posedge core_clk) disable iff (sys_rst) loop_nmi_request);
   irq_cover_c: cover property (@(posedge core_clk) disable iff (sys_rst) interval_irq_request);
   rerun_cover_c: cover property (@(posedge core_clk) disable iff (sys_rst) run_r && restart);

endmodule

`default_nettype wire

// File: dv/wit_osc_model.sv
// Oscillator start-up model seen by the settle counter after a STOP release.
// Assumes stop_mode is a level on core_clk that drops on the edge of the STOP release.
`timescale 1ns/10ps
`default_nettype none

module wit_osc_model (
   input wire logic core_clk, // Main clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic stop_mode, // CPU in software STOP
   input wire logic [3:0] start_dly, // Cycles until oscillation starts
   output logic osc_running // Oscillator started
);
   logic [3:0] left_r;

   // Oscillation is lost during STOP and restarts late; the wait must not include that delay
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         osc_running <= 1'b1;
         left_r <= 4'h0;
      end else if (stop_mode) begin
         osc_running <= 1'b0;
         left_r <= start_dly;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
      end else begin
         osc_running <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: dv/wit_timer_tb_top.sv
// Self-checking bench for the watchdog/interval timer.
// Assumes EXP_TRIM of 10, so select 0 gives 16 cycles and select 7 gives 4096.
`timescale 1ns/10ps
`default_nettype none

module wit_timer_tb_top;
   localparam int TRIM = 10;
   logic core_clk, sys_rst, reg_wr, reg_rd, idle_mode, stop_mode, subclk_sel, stop_release;
   logic osc_running, interval_irq_mask, loop_nmi_request, interval_irq_request;
   logic settle_busy, settle_done;
   logic [31:0] reg_addr, rnd;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [2:0] interval_irq_priority, interval_irq_level, interval_irq_rank;
   logic [3:0] start_dly;
   int fail_count, cmp_count, cyc, irq_n, nmi_n, n, a, b;

   wit_timer #(.EXP_TRIM(5'(TRIM))) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .idle_mode(idle_mode), .stop_mode(stop_mode),
      .subclk_sel(subclk_sel), .stop_release(stop_release), .osc_running(osc_running),
      .interval_irq_mask(interval_irq_mask), .interval_irq_priority(interval_irq_priority),
      .loop_nmi_request(loop_nmi_request), .interval_irq_request(interval_irq_request),
      .interval_irq_level(interval_irq_level), .interval_irq_rank(interval_irq_rank),
      .settle_busy(settle_busy), .settle_done(settle_done));
   wit_osc_model osc (.core_clk(core_clk), .sys_rst(sys_rst), .stop_mode(stop_mode),
      .start_dly(start_dly), .osc_running(osc_running));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int ovf_per(input int c);
      return 1 << ((c == 7 ? 22 : 14 + c) - TRIM);
   endfunction
   function automatic int settle_per(input int c);
      return 1 << ((c == 0 ? 14 : 15 + c) - TRIM);
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] ad, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] ad, output logic [7:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_req(input bit nmi, input int lim, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (!((nmi ? loop_nmi_request : interval_irq_request) === 1'b1) && k < lim);
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (interval_irq_request === 1'b1) irq_n++;
      if (loop_nmi_request === 1'b1) nmi_n++;
      if (cyc == 70000) begin
         fail_count++;
         close_out();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reg_wr, reg_rd, idle_mode, stop_mode, subclk_sel, stop_release} = '0;
      {interval_irq_mask, reg_addr, reg_wdata} = '0;
      sys_rst = 1'b1;
      rnd = 32'h645D;
      interval_irq_priority = 3'h5;
      start_dly = 4'h3;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(wit_pkg::OSC_SETTLE_ADDR, rv); check("settle_rst", rv, 8'h04);
      rd(wit_pkg::OVF_SELECT_ADDR, rv); check("select_rst", rv, 8'h00);
      rd(wit_pkg::WDT_MODE_ADDR, rv); check("mode_rst", rv, 8'h00);
      rd(32'hFFFFF386, rv); check("unmapped", rv, 8'h00);
      wr(wit_pkg::OSC_SETTLE_ADDR, 8'h05);
      rd(wit_pkg::OSC_SETTLE_ADDR, rv); check("settle_bad", rv, 8'h04);
      // Settle wait for every legal code, with a random oscillator start-up delay
      for (int c = 0; c < 5; c++) begin
         rnd = xs(rnd);
         start_dly <= 4'(rnd[2:0] + 8);
         wr(wit_pkg::OSC_SETTLE_ADDR, 8'(c));
         // Oscillator is off through STOP, so its restart delay comes on top of the settle count
         stop_mode <= 1'b1;
         repeat (4) @(posedge core_clk);
         stop_mode <= 1'b0;
         stop_release <= 1'b1;
         @(posedge core_clk);
         stop_release <= 1'b0;
         #1 check("settle_busy", settle_busy, 1'b1);
         n = 0;
         while (settle_done !== 1'b1 && n < 700) begin
            @(posedge core_clk);
            #1 n++;
         end
         a = settle_per(c) + 32'(start_dly);
         check("settle_len", n >= a && n <= a + 6, 1'b1);
      end
      // Interval mode, every overflow select; a new select waits for the restart
      rd(wit_pkg::WDT_MODE_ADDR, rv); check("mode_idle", rv, 8'h00);
      wr(wit_pkg::WDT_MODE_ADDR, 8'h80);
      for (int c = 0; c < 8; c++) begin
         wr(wit_pkg::OVF_SELECT_ADDR, 8'(c));
         if (c > 0) begin
            wait_req(0, 5000, n);
            wait_req(0, 5000, n);
            check("select_late", n, ovf_per(c - 1));
         end
         wr(wit_pkg::WDT_MODE_ADDR, 8'h80);
         wait_req(0, 5000, n);
         check("first_short", n <= ovf_per(c) + 2, 1'b1);
         wait_req(0, 5000, n);
         check("interval", n, ovf_per(c));
         check("irq_level", interval_irq_level, interval_irq_priority);
         check("irq_rank", interval_irq_rank, 3'h0);
      end
      wr(wit_pkg::OVF_SELECT_ADDR, 8'h00);
      wr(wit_pkg::WDT_MODE_ADDR, 8'h00);
      rd(wit_pkg::WDT_MODE_ADDR, rv); check("run_sticky", rv, 8'h80);
      // Idle, stop and subclock each freeze the count; restarted first
      for (int k = 0; k < 3; k++) begin
         wr(wit_pkg::WDT_MODE_ADDR, 8'h80);
         a = irq_n;
         {subclk_sel, stop_mode, idle_mode} <= 3'(1 << k);
         repeat (100) @(posedge core_clk);
         {subclk_sel, stop_mode, idle_mode} <= 3'h0;
         check("frozen", irq_n - a, 0);
         wait_req(0, 40, n);
         check("resumes", n < 40, 1'b1);
      end
      // Let the last request reach irq_n before the baseline is taken
      repeat (2) @(posedge core_clk);
      rnd = xs(rnd);
      interval_irq_priority <= rnd[2:0];
      interval_irq_mask <= 1'b1;
      a = irq_n;
      repeat (100) @(posedge core_clk);
      check("masked", irq_n - a, 0);
      interval_irq_mask <= 1'b0;
      wait_req(0, 40, n);
      check("unmasked", interval_irq_level, interval_irq_priority);
      check("unmasked_req", interval_irq_request, 1'b1);
      // Watchdog mode: sticky, restarts hold off the request, then it times out
      // Longest select first, so no short watchdog period fires during setup
      wr(wit_pkg::OVF_SELECT_ADDR, 8'h07);
      wr(wit_pkg::WDT_MODE_ADDR, 8'h90);
      wr(wit_pkg::WDT_MODE_ADDR, 8'h00);
      rd(wit_pkg::WDT_MODE_ADDR, rv); check("mode_sticky", rv, 8'h90);
      wr(wit_pkg::WDT_MODE_ADDR, 8'h80);
      a = irq_n;
      b = nmi_n;
      for (int k = 0; k < 5; k++) begin
         rnd = xs(rnd);
         repeat (700 + rnd[7:0]) @(posedge core_clk);
         wr(wit_pkg::WDT_MODE_ADDR, 8'h80);
      end
      check("restart_holds", nmi_n - b, 0);
      wait_req(1, 5000, n);
      check("nmi_due", n <= ovf_per(7), 1'b1);
      wait_req(1, 5000, n);
      check("nmi_period", n, ovf_per(7));
      check("no_maskable", irq_n - a, 0);
      close_out();
   end
endmodule
`default_nettype wire
